/* dv/sct_spi_clock_timing_assertions.sv */
// Checker for the serial clock timing block.
// Assumes binding to the top module; config moves only while disabled.
`timescale 1ns/100ps
`default_nettype none
module sct_spi_clock_timing_checker #(
  parameter int WordBits = 8,
  parameter int DivW = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic portActive,
  input wire logic masterMode,
  input wire logic clockPolaritySelect,
  input wire logic [DivW-1:0] serialRateDivider,
  input wire logic busy,
  input wire logic rxValid,
  input wire logic [WordBits-1:0] rxData,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic slaveSelectOutN,
  input wire logic slaveSelectN,
  input wire logic slaveMisoOe
);
  // ****************
  // Half period gap
  // ****************
  logic [9:0] gap;
  logic lead;
  int hExp;
  assign hExp = (serialRateDivider == 0) ? 2 : int'(serialRateDivider) + 1;
  // Lead half period plus first half period before the first edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gap <= 10'h000;
      lead <= 1'b0;
    end else if ($fell(slaveSelectOutN)) begin
      gap <= 10'h001;
      lead <= 1'b1;
    end else if ($changed(sckOut)) begin
      gap <= 10'h001;
      lead <= 1'b0;
    end else if (gap != 10'h3FF) begin
      gap <= gap + 10'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sck_idle_a: assert property (portActive && $past(portActive) &&
    sckOe && $past(sckOe) && slaveSelectOutN
    |-> sckOut == clockPolaritySelect) else $error("sck idle level wrong");
  slave_quiet_a: assert property (masterMode && portActive &&
    $past(portActive) |-> !slaveMisoOe)
    else $error("slave drives in master mode");
  master_quiet_a: assert property (!masterMode && portActive &&
    $past(portActive) |-> !sckOe) else $error("clock driven in slave mode");
  rx_pulse_a: assert property (rxValid |=> !rxValid)
    else $error("rxValid longer than a cycle");
  rx_hold_a: assert property ($changed(rxData) |-> rxValid)
    else $error("rxData moved without rxValid");
  sck_min_a: assert property (sckOe && $changed(sckOut)
    |=> $stable(sckOut)) else $error("sck faster than two cycles");
  sck_gap_a: assert property (sckOe && $changed(sckOut)
    |-> int'(gap) == (lead ? 2 * hExp : hExp))
    else $error("sck half period wrong");
  select_busy_a: assert property ($fell(slaveSelectOutN) |-> busy)
    else $error("frame without busy");
  miso_release_a: assert property (slaveSelectN [*4]
    |-> !slaveMisoOe) else $error("miso driven while deselected");
  c_master: cover property (rxValid && masterMode);
  c_slave: cover property (rxValid && !masterMode);
  c_slow: cover property (sckOe && $changed(sckOut) && hExp == 4);
endmodule
bind sct_spi_clock_timing sct_spi_clock_timing_checker #(
  .WordBits(WordBits),
  .DivW(DivW)
) i_sct_spi_clock_timing_checker (.*);
`default_nettype wire

/* dv/sct_spi_clock_timing_bench.sv */
// Self-checking bench for the serial clock timing block.
// Assumes the checker is bound and the peer model is compiled.
`timescale 1ns/100ps
`default_nettype none
module sct_spi_clock_timing_bench;
  logic core_clk = 0, tick = 0, rst = 1, linkSck = 0;
  logic portEnable = 0, masterMode = 0, clockPhaseSelect = 0;
  logic clockPolaritySelect = 0, txValid = 0, misoIn;
  logic slaveSelectN = 1, slaveMosiIn = 0;
  logic [7:0] serialRateDivider = 8'h00, txData = 8'h00;
  logic [7:0] reply = 8'h00, rxData, peerGot;
  logic busy, rxValid, sckOut, mosiOut, slaveSelectOutN;
  logic portActive, sckOe, mosiOe, slaveMisoOut, slaveMisoOe;
  logic [7:0] expQ[$];
  int miscompares = 0, checks = 0;
  always #10 core_clk = ~core_clk;
  // Link base clock, unrelated in phase
  initial #7 forever #15 tick = ~tick;
  sct_spi_clock_timing i_sct_spi_clock_timing (.core_clk(core_clk),
    .rst(rst), .linkSck(linkSck), .portEnable(portEnable),
    .masterMode(masterMode), .clockPhaseSelect(clockPhaseSelect),
    .clockPolaritySelect(clockPolaritySelect),
    .serialRateDivider(serialRateDivider), .txValid(txValid),
    .txData(txData), .busy(busy), .rxValid(rxValid), .rxData(rxData),
    .portActive(portActive), .sckOut(sckOut), .sckOe(sckOe),
    .mosiOut(mosiOut), .mosiOe(mosiOe),
    .slaveSelectOutN(slaveSelectOutN), .misoIn(misoIn),
    .slaveSelectN(slaveSelectN), .slaveMosiIn(slaveMosiIn),
    .slaveMisoOut(slaveMisoOut), .slaveMisoOe(slaveMisoOe));
  sct_spi_peer i_sct_spi_peer (.sckOut(sckOut),
    .slaveSelectOutN(slaveSelectOutN), .mosiOut(mosiOut),
    .misoIn(misoIn), .phase(clockPhaseSelect), .reply(reply),
    .got(peerGot));
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Settings move only while the port is off
  task automatic setup(input logic m, ph, po, input logic [7:0] d);
    @(posedge core_clk) portEnable <= 0;
    @(posedge core_clk) masterMode <= m;
    clockPhaseSelect <= ph;
    clockPolaritySelect <= po;
    serialRateDivider <= d;
    linkSck <= po;
    repeat (2) @(posedge core_clk);
    portEnable <= 1;
    repeat (2) @(posedge core_clk);
    check({7'h00, portActive}, 8'h01);
  endtask
  task automatic mframe(input logic [7:0] tx, input logic [7:0] rp);
    @(posedge core_clk) reply <= rp;
    txData <= tx;
    txValid <= 1;
    expQ.push_back(rp);
    @(posedge core_clk) txValid <= 0;
    @(negedge core_clk);
    check({6'h00, sckOe, mosiOe}, 8'h03);
    for (int i = 0; i < 3000 && busy; i++) @(negedge core_clk);
    check(peerGot, tx);
  endtask
  task automatic sframe(input logic [7:0] b, input logic [7:0] tx);
    logic [7:0] miso;
    logic [7:0] mask;
    miso = 8'h00;
    // Phase clear: first bit out belongs to the previous word
    mask = clockPhaseSelect ? 8'hFF : 8'h7F;
    expQ.push_back(b);
    @(posedge core_clk) txData <= tx;
    txValid <= 1;
    @(posedge core_clk) txValid <= 0;
    repeat (2) @(posedge core_clk);
    @(posedge tick) slaveSelectN <= 0;
    // Bit time of 12 core cycles keeps below a tenth
    for (int i = 7; i >= 0; i--) begin
      if (!clockPhaseSelect) slaveMosiIn <= b[i];
      repeat (4) @(posedge tick);
      if (!clockPhaseSelect) miso[i] = slaveMisoOut;
      linkSck <= ~linkSck;
      if (clockPhaseSelect) slaveMosiIn <= b[i];
      repeat (4) @(posedge tick);
      if (clockPhaseSelect) miso[i] = slaveMisoOut;
      if (i == 4) check({7'h00, slaveMisoOe}, 8'h01);
      linkSck <= ~linkSck;
    end
    check(miso & mask, tx & mask);
    repeat (4) @(posedge tick);
    slaveSelectN <= 1;
    slaveMosiIn <= ~slaveMosiIn;
    repeat (12) @(posedge core_clk);
  endtask
  always @(negedge core_clk) begin
    if (rxValid) check(rxData, expQ.size() ? expQ.pop_front() : 8'hXX);
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  // ****************
  // Sequence
  // ****************
  initial begin
    void'($urandom(62));
    repeat (5) @(posedge core_clk);
    rst <= 0;
    for (int m = 0; m < 4; m++) begin
      setup(1, m[0], m[1], 8'(m));
      repeat (2) mframe(8'($urandom), 8'($urandom));
    end
    for (int m = 0; m < 4; m++) begin
      setup(0, m[0], m[1], 8'($urandom));
      repeat (2) sframe(8'($urandom), 8'($urandom));
    end
    repeat (5) @(posedge core_clk);
    conclude();
  end
endmodule
`default_nettype wire

/* dv/sct_spi_peer.sv */
// Behavioural slave peer answering the block's master frames.
// Assumes it sees the master pins directly.
`timescale 1ns/100ps
`default_nettype none
module sct_spi_peer (
  // Master pins
  input wire logic sckOut,
  input wire logic slaveSelectOutN,
  input wire logic mosiOut,
  output logic misoIn,
  // Setup and result
  input wire logic phase,
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  int n = 0;
  initial misoIn = 1'b0;
  initial got = 8'h00;
  always @(negedge slaveSelectOutN) begin
    n = 0;
    misoIn = reply[7];
  end
  // Released line must not keep its last value
  always @(posedge slaveSelectOutN) misoIn = ~misoIn;
  always @(sckOut) begin
    if (!slaveSelectOutN) begin
      n++;
      if (n[0] != phase) begin
        got = {got[6:0], mosiOut};
      end else if (n < 16) begin
        misoIn = reply[7 - n / 2];
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/sct_defines.svh */
// Constants for the serial clock timing block.
// Assumes a 50 MHz core clock and 8-bit words.
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH
`define SCT_CORE_HZ 50000000
`define SCT_MASTER_MAX_HZ 12500000
`define SCT_WORD_BITS 8
`define SCT_DIV_RESET 8'h00
`define SCT_DIV_W 8
`endif

/* rtl/sct_pkg.sv */
// Types for the serial clock timing block.
// Assumes nothing of its surroundings.
package sct_pkg;
  typedef enum logic [1:0] {
    SCT_IDLE = 2'b00,
    SCT_LEAD = 2'b01,
    SCT_SHIFT = 2'b10,
    SCT_TRAIL = 2'b11
  } sct_master_e;
endpackage

/* rtl/sct_spi_clock_timing.sv */
// Serial port clock timing: master clock generation and slave link logic.
// Assumes the peer's serial clock is a clock port and that settings are
// changed only while the port is disabled.
`timescale 1ns/100ps
`default_nettype none
`include "sct_defines.svh"

// Notes on behaviour
// - Phase and polarity together give four clock configurations.
// - Phase picks which serial clock edge latches incoming data.
// - Polarity picks the active edge and so the idle clock level.
// - Master and slave must agree on phase and polarity.
// - Phase and polarity should only change while the port is disabled.
// - The rate divider sets the master serial clock frequency.
// - The rate divider has no effect in slave mode.
// - Master bit rate never exceeds half the core clock nor 12.5 MHz.
// - Full-duplex slave works up to a tenth of the core clock.
// - A receive-only slave accepts up to a quarter of the core clock.
module sct_spi_clock_timing #(
  parameter int WordBits = `SCT_WORD_BITS,
  parameter int DivW = `SCT_DIV_W
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic linkSck,
  // Configuration
  input wire logic portEnable,
  input wire logic masterMode,
  input wire logic clockPhaseSelect,
  input wire logic clockPolaritySelect,
  input wire logic [DivW-1:0] serialRateDivider,
  // Data
  input wire logic txValid,
  input wire logic [WordBits-1:0] txData,
  output logic busy,
  output logic rxValid,
  output logic [WordBits-1:0] rxData,
  output logic portActive,
  // Master pins
  output logic sckOut,
  output logic sckOe,
  output logic mosiOut,
  output logic mosiOe,
  output logic slaveSelectOutN,
  input wire logic misoIn,
  // Slave pins
  input wire logic slaveSelectN,
  input wire logic slaveMosiIn,
  output logic slaveMisoOut,
  output logic slaveMisoOe
);
  localparam int EdgeW = $clog2(2 * WordBits);
  localparam int BitW = $clog2(WordBits);
  localparam int MinBit =
    (`SCT_CORE_HZ + `SCT_MASTER_MAX_HZ - 1) / `SCT_MASTER_MAX_HZ;
  localparam int MinHalfInt = (MinBit < 2) ? 1 : (MinBit + 1) / 2;
  localparam logic [DivW:0] MinHalf = (DivW + 1)'(MinHalfInt);
  localparam logic [EdgeW-1:0] LastEdge = EdgeW'(2 * WordBits - 1);
  localparam logic [BitW-1:0] LastBit = BitW'(WordBits - 1);

  initial begin
    if (WordBits < 2 || WordBits != (1 << BitW) || DivW < 1) begin
      $error("sct_spi_clock_timing: unsupported parameters");
    end
  end

  // ********************************************************
  // Settings, taken only while disabled
  // ********************************************************
  logic cfgPha;
  logic cfgPol;
  logic cfgMaster;
  logic [DivW-1:0] cfgDiv;

  // Frozen while enabled; master start still reads clockPhaseSelect directly, not only cfgPha
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfgPha <= 1'b0;
      cfgPol <= 1'b0;
      cfgMaster <= 1'b0;
      cfgDiv <= `SCT_DIV_RESET;
    end else if (!portEnable) begin
      cfgPha <= clockPhaseSelect;
      cfgPol <= clockPolaritySelect;
      cfgMaster <= masterMode;
      cfgDiv <= serialRateDivider;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      portActive <= 1'b0;
    end else begin
      portActive <= portEnable;
    end
  end

  wire masterOn = portActive && cfgMaster;
  wire slaveOn = portActive && !cfgMaster;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [1:0] misoSync;
  logic [1:0] nssSync;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      misoSync <= 2'b00;
      nssSync <= 2'b11;
    end else begin
      misoSync <= {misoSync[0], misoIn};
      nssSync <= {nssSync[0], slaveSelectN};
    end
  end

  // ********************************************************
  // Master clock generator and shifter
  // ********************************************************
  sct_pkg::sct_master_e mState;
  logic [DivW:0] halfCnt;
  logic [EdgeW-1:0] edgeCnt;
  logic [WordBits-1:0] mTx;
  logic [WordBits-1:0] mRx;

  // Half period is divider+1 core clocks, floored at the rate limit
  wire [DivW:0] divHalf = {1'b0, cfgDiv} + (DivW + 1)'(1);
  wire [DivW:0] halfLen = (divHalf < MinHalf) ? MinHalf : divHalf;
  wire halfTick = (halfCnt == halfLen - (DivW + 1)'(1));
  wire leadEdge = !edgeCnt[0];
  wire sampleEdge = (leadEdge != cfgPha);
  wire mStart = masterOn && txValid && (mState == sct_pkg::SCT_IDLE);
  // Master pin timing only; the slave path never reads the divider

  always_ff @(posedge core_clk) begin
    if (rst || mState == sct_pkg::SCT_IDLE || halfTick) begin
      halfCnt <= '0;
    end else begin
      halfCnt <= halfCnt + (DivW + 1)'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mState <= sct_pkg::SCT_IDLE;
    end else begin
      case (mState)
        sct_pkg::SCT_IDLE: begin
          if (mStart) begin
            mState <= sct_pkg::SCT_LEAD;
          end
        end
        sct_pkg::SCT_LEAD: begin
          if (halfTick) begin
            mState <= sct_pkg::SCT_SHIFT;
          end
        end
        sct_pkg::SCT_SHIFT: begin
          if (halfTick && edgeCnt == LastEdge) begin
            mState <= sct_pkg::SCT_TRAIL;
          end
        end
        sct_pkg::SCT_TRAIL: begin
          if (halfTick) begin
            mState <= sct_pkg::SCT_IDLE;
          end
        end
        default: begin
          mState <= sct_pkg::SCT_IDLE;
        end
      endcase
    end
  end

  // Serial clock idles at the polarity level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sckOut <= 1'b0;
      edgeCnt <= '0;
    end else if (mState == sct_pkg::SCT_SHIFT && halfTick) begin
      sckOut <= !sckOut;
      edgeCnt <= edgeCnt + EdgeW'(1);
    end else if (mState == sct_pkg::SCT_IDLE) begin
      sckOut <= cfgPol;
      edgeCnt <= '0;
    end
  end

  // Phase clear puts the first bit out before the first edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mTx <= '0;
      mosiOut <= 1'b0;
    end else if (mStart) begin
      if (!clockPhaseSelect && !cfgPha) begin
        mosiOut <= txData[WordBits-1];
        mTx <= {txData[WordBits-2:0], 1'b0};
      end else begin
        mTx <= txData;
      end
    end else if (mState == sct_pkg::SCT_SHIFT && halfTick && !sampleEdge) begin
      mosiOut <= mTx[WordBits-1];
      mTx <= {mTx[WordBits-2:0], 1'b0};
    end
  end

  logic [1:0] mSamplePipe;
  logic [1:0] mDonePipe;

  // Capture two cycles late so the synchroniser delay is matched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mSamplePipe <= 2'b00;
      mDonePipe <= 2'b00;
    end else begin
      mSamplePipe <= {mSamplePipe[0],
        mState == sct_pkg::SCT_SHIFT && halfTick && sampleEdge};
      mDonePipe <= {mDonePipe[0],
        mState == sct_pkg::SCT_TRAIL && halfTick};
    end
  end

  // Synchroniser delay eats into the slave's data valid window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mRx <= '0;
    end else if (mSamplePipe[1]) begin
      mRx <= {mRx[WordBits-2:0], misoSync[1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      slaveSelectOutN <= 1'b1;
      sckOe <= 1'b0;
      mosiOe <= 1'b0;
    end else begin
      sckOe <= masterOn;
      mosiOe <= masterOn;
      if (mStart) begin
        slaveSelectOutN <= 1'b0;
      end else if (mState == sct_pkg::SCT_TRAIL && halfTick) begin
        slaveSelectOutN <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Slave link domain
  // ********************************************************
  // Sampling edge is made rising by folding the mode into the clock
  wire linkClk = linkSck ^ (cfgPol ^ cfgPha);
  wire linkClr = slaveSelectN || !slaveOn;
  logic [BitW-1:0] sBitCnt;
  logic [BitW-1:0] sDrvCnt;
  logic [WordBits-1:0] sRx;
  logic [WordBits-1:0] sRxWord;
  logic sRxTog;
  logic [WordBits-1:0] sTxWord;

  // Frame ends with its own select; no clock edge is relied on after
  always_ff @(posedge linkClk or posedge linkClr) begin
    if (linkClr) begin
      sBitCnt <= '0;
      sRx <= '0;
    end else begin
      sBitCnt <= sBitCnt + BitW'(1);
      sRx <= {sRx[WordBits-2:0], slaveMosiIn};
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      sRxWord <= '0;
      sRxTog <= 1'b0;
    end else if (!linkClr && sBitCnt == LastBit) begin
      sRxWord <= {sRx[WordBits-2:0], slaveMosiIn};
      sRxTog <= !sRxTog;
    end
  end

  always_ff @(negedge linkClk or posedge linkClr) begin
    if (linkClr) begin
      sDrvCnt <= '0;
    end else begin
      sDrvCnt <= sDrvCnt + BitW'(1);
    end
  end

  // Phase clear: next frame's first bit is set by this frame's last edge
  always_ff @(negedge linkClk or posedge rst) begin
    if (rst) begin
      slaveMisoOut <= 1'b0;
    end else if (!linkClr) begin
      if (cfgPha) begin
        slaveMisoOut <= sTxWord[LastBit - sDrvCnt];
      end else if (sDrvCnt == LastBit) begin
        slaveMisoOut <= sTxWord[WordBits-1];
      end else begin
        slaveMisoOut <= sTxWord[LastBit - sDrvCnt - BitW'(1)];
      end
    end
  end

  // ********************************************************
  // Slave core side
  // ********************************************************
  logic [2:0] rxTogSync;

  // Transmit word only changes while the peer is not selecting us
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sTxWord <= '0;
    end else if (slaveOn && txValid && nssSync[1]) begin
      sTxWord <= txData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxTogSync <= 3'b000;
      slaveMisoOe <= 1'b0;
    end else begin
      rxTogSync <= {rxTogSync[1:0], sRxTog};
      slaveMisoOe <= slaveOn && !nssSync[1];
    end
  end

  wire sRxEvent = rxTogSync[2] ^ rxTogSync[1];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxValid <= 1'b0;
      rxData <= '0;
    end else begin
      rxValid <= 1'b0;
      if (mDonePipe[1]) begin
        rxValid <= 1'b1;
        rxData <= mRx;
      end else if (slaveOn && sRxEvent) begin
        rxValid <= 1'b1;
        rxData <= sRxWord;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (mState != sct_pkg::SCT_IDLE) || mStart ||
        mDonePipe[0] || (slaveOn && !nssSync[1]);
    end
  end
endmodule
`default_nettype wire
